// >>> ptwf_pkg.sv
// ptwf_pkg: constants, types and helpers for the trigger output waveform block
// assumes a 250 MHz system clock and a 32-bit nanosecond system time from outside

package ptwf_pkg;

   localparam int NUM_UNITS = 4;
   localparam int UNIT_IDX_W = 2;
   localparam int AXI_ADDR_W = 16;
   // clock period and pulse width unit, both in ns
   localparam int CLK_NS = 4;
   localparam int PW_UNIT_NS = 8;
   localparam int PW_CYC_PER_UNIT = PW_UNIT_NS / CLK_NS;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [15:0] OFS_UNIT_INDEX = 16'h0520;
   localparam logic [15:0] OFS_ENABLE = 16'h0524;
   localparam logic [15:0] OFS_STATUS = 16'h0528;
   localparam logic [15:0] OFS_TARGET = 16'h0530;
   localparam logic [15:0] OFS_CTRL1 = 16'h0538;
   localparam logic [15:0] OFS_CTRL2 = 16'h053c;
   localparam logic [15:0] OFS_CTRL3 = 16'h0540;
   localparam logic [15:0] OFS_CTRL4 = 16'h0544;
   localparam logic [15:0] OFS_CTRL5 = 16'h0548;

   // field positions and masks
   localparam int CASC_EN_BIT = 31;
   localparam int TAIL_BIT = 30;
   localparam int NOW_BIT = 25;
   localparam int EDGE_BIT = 23;
   localparam int PAT_LSB = 20;
   localparam int COUNT_LSB = 16;
   localparam int PW_FULL_W = 24;
   localparam logic [31:0] CTRL1_WMASK = 32'hcff0_ffff;
   localparam logic [31:0] CTRL5_WMASK = 32'h00ff_ffff;
   localparam logic [31:0] FULL_WMASK = 32'hffff_ffff;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic WAVE_RESET = 1'b1;

   // pattern selector codes
   localparam logic [2:0] PAT_FALL = 3'h0;
   localparam logic [2:0] PAT_RISE = 3'h1;
   localparam logic [2:0] PAT_NPULSE = 3'h2;
   localparam logic [2:0] PAT_PPULSE = 3'h3;
   localparam logic [2:0] PAT_NPER = 3'h4;
   localparam logic [2:0] PAT_PPER = 3'h5;
   localparam logic [2:0] PAT_SHIFT = 3'h6;
   localparam logic [2:0] PAT_RSVD = 3'h7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} ptwf_state_t;

   // one committed register write
   typedef struct packed {
      logic valid;
      logic [AXI_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } ptwf_wr_t;

   // byte-lane merge, reserved bits forced to zero
   function automatic logic [31:0] ptwf_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res & mask;
   endfunction

   function automatic logic ptwf_mapped(input logic [AXI_ADDR_W-1:0] a);
      return (a == OFS_UNIT_INDEX) || (a == OFS_ENABLE) || (a == OFS_STATUS) ||
             (a == OFS_TARGET) || (a == OFS_CTRL1) || (a == OFS_CTRL2) ||
             (a == OFS_CTRL3) || (a == OFS_CTRL4) || (a == OFS_CTRL5);
   endfunction

   // a zero length would never end a phase, so clamp to one cycle
   function automatic logic [31:0] ptwf_min1(input logic [31:0] v);
      return (v == 32'h0) ? 32'h1 : v;
   endfunction

endpackage

// >>> ptwf_axil_slave.sv
// ptwf_axil_slave: AXI4-Lite slave front end for the trigger waveform registers
// assumes the top supplies read data combinationally from the read address
`timescale 1ns/1ps

module ptwf_axil_slave (
   input wire logic i_clk, // system clock
   input wire logic i_reset_n, // async reset, active low
   input wire logic i_awvalid, // write address valid
   output logic o_awready, // write address ready
   input wire logic [ptwf_pkg::AXI_ADDR_W-1:0] i_awaddr, // write address
   input wire logic i_wvalid, // write data valid
   output logic o_wready, // write data ready
   input wire logic [31:0] i_wdata, // write data
   input wire logic [3:0] i_wstrb, // byte strobes
   output logic o_bvalid, // write response valid
   input wire logic i_bready, // write response ready
   output logic [1:0] o_bresp, // write response
   input wire logic i_arvalid, // read address valid
   output logic o_arready, // read address ready
   input wire logic [ptwf_pkg::AXI_ADDR_W-1:0] i_araddr, // read address
   output logic o_rvalid, // read data valid
   input wire logic i_rready, // read data ready
   output logic [31:0] o_rdata, // read data
   output logic [1:0] o_rresp, // read response
   input wire logic [31:0] i_rd_data, // register value at i_araddr
   output ptwf_pkg::ptwf_wr_t o_wr // committed write, one-cycle pulse
);
   import ptwf_pkg::*;

   logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
   logic [AXI_ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic commit;

   // address and data are held until both are present; one write at a time
   assign o_awready = !aw_full_reg;
   assign o_wready = !w_full_reg;
   assign commit = aw_full_reg && w_full_reg && !bvalid_reg;
   assign o_wr.valid = commit && ptwf_mapped(awaddr_reg);
   assign o_wr.addr = awaddr_reg;
   assign o_wr.data = wdata_reg;
   assign o_wr.strb = wstrb_reg;
   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;
   assign o_arready = !rvalid_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rdata = rdata_reg;
   assign o_rresp = rresp_reg;

   // write address holding
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_full_reg <= 1'b0;
         awaddr_reg <= '0;
      end else if (commit) begin
         aw_full_reg <= 1'b0;
      end else if (i_awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         awaddr_reg <= i_awaddr;
      end
   end

   // write data holding
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         w_full_reg <= 1'b0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else if (commit) begin
         w_full_reg <= 1'b0;
      end else if (i_wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         wdata_reg <= i_wdata;
         wstrb_reg <= i_wstrb;
      end
   end

   // write response; unmapped addresses are dropped with an error
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (commit) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= ptwf_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // read channel, data captured at the address handshake
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= RESP_OKAY;
      end else if (i_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= ptwf_mapped(i_araddr) ? i_rd_data : 32'h0;
         rresp_reg <= ptwf_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

// >>> ptwf_top.sv
// ptwf_top: four time-triggered waveform output units behind an AXI4-Lite slave
// assumes I_SYS_TIME is a nanosecond count synchronous to I_CLK
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module ptwf_top (
   input wire logic I_CLK, // 250 MHz system clock
   input wire logic I_RESET_N, // async reset, active low
   input wire logic [31:0] I_SYS_TIME, // local system time, ns
   input wire logic I_AWVALID, // write address valid
   output logic O_AWREADY, // write address ready
   input wire logic [ptwf_pkg::AXI_ADDR_W-1:0] I_AWADDR, // write address
   input wire logic I_WVALID, // write data valid
   output logic O_WREADY, // write data ready
   input wire logic [31:0] I_WDATA, // write data
   input wire logic [3:0] I_WSTRB, // byte strobes
   output logic O_BVALID, // write response valid
   input wire logic I_BREADY, // write response ready
   output logic [1:0] O_BRESP, // write response
   input wire logic I_ARVALID, // read address valid
   output logic O_ARREADY, // read address ready
   input wire logic [ptwf_pkg::AXI_ADDR_W-1:0] I_ARADDR, // read address
   output logic O_RVALID, // read data valid
   input wire logic I_RREADY, // read data ready
   output logic [31:0] O_RDATA, // read data
   output logic [1:0] O_RRESP, // read response
   output logic [ptwf_pkg::NUM_UNITS-1:0] O_TRIG_OUT // trigger output pins
);
   import ptwf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // shared state

   ptwf_wr_t wr;
   logic [31:0] rd_data;
   logic [UNIT_IDX_W-1:0] idx_reg;
   logic [NUM_UNITS-1:0] en_reg;
   logic [NUM_UNITS-1:0] running, done, tail_done;
   logic chain_stop;
   logic [31:0] tgt_q [NUM_UNITS];
   logic [31:0] c1_q [NUM_UNITS];
   logic [31:0] c2_q [NUM_UNITS];
   logic [31:0] c3_q [NUM_UNITS];
   logic [31:0] c4_q [NUM_UNITS];
   logic [31:0] c5_q [NUM_UNITS];

   // output level at a given point of a run
   function automatic logic wave_at(input logic [2:0] pat, input logic [31:0] pos,
                                    input logic [31:0] pw, input logic [3:0] bi,
                                    input logic [15:0] bits);
      logic lvl;
      lvl = 1'b0;
      case (pat)
         PAT_FALL: lvl = 1'b0;
         PAT_RISE: lvl = 1'b1;
         PAT_NPULSE, PAT_NPER: lvl = (pos >= pw);
         PAT_PPULSE, PAT_PPER: lvl = (pos < pw);
         PAT_SHIFT: lvl = bits[4'hf - bi];
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus front end

   ptwf_axil_slave u_bus (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_awvalid(I_AWVALID),
      .o_awready(O_AWREADY),
      .i_awaddr(I_AWADDR),
      .i_wvalid(I_WVALID),
      .o_wready(O_WREADY),
      .i_wdata(I_WDATA),
      .i_wstrb(I_WSTRB),
      .o_bvalid(O_BVALID),
      .i_bready(I_BREADY),
      .o_bresp(O_BRESP),
      .i_arvalid(I_ARVALID),
      .o_arready(O_ARREADY),
      .i_araddr(I_ARADDR),
      .o_rvalid(O_RVALID),
      .i_rready(I_RREADY),
      .o_rdata(O_RDATA),
      .o_rresp(O_RRESP),
      .i_rd_data(rd_data),
      .o_wr(wr)
   );

   // unit index and enable bits, both in byte lane 0
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         idx_reg <= '0;
         en_reg <= '0;
      end else if (wr.valid && wr.strb[0]) begin
         if (wr.addr == OFS_UNIT_INDEX) begin
            idx_reg <= wr.data[UNIT_IDX_W-1:0];
         end
         if (wr.addr == OFS_ENABLE) begin
            en_reg <= wr.data[NUM_UNITS-1:0];
         end
      end
   end

   // read mux; per-unit registers show the indexed unit only
   always_comb begin
      rd_data = 32'h0;
      case (I_ARADDR)
         OFS_UNIT_INDEX: rd_data = 32'(idx_reg);
         OFS_ENABLE: rd_data = 32'(en_reg);
         OFS_STATUS: rd_data = 32'({done, running});
         OFS_TARGET: rd_data = tgt_q[idx_reg];
         OFS_CTRL1: rd_data = c1_q[idx_reg];
         OFS_CTRL2: rd_data = c2_q[idx_reg];
         OFS_CTRL3: rd_data = c3_q[idx_reg];
         OFS_CTRL4: rd_data = c4_q[idx_reg];
         OFS_CTRL5: rd_data = c5_q[idx_reg];
         default: rd_data = 32'h0;
      endcase
   end

   // chain ends once any tail unit has finished
   assign chain_stop = |tail_done;

   ////////////////////////////////////////////////////////////////////////////
   // one waveform engine per trigger unit

   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      logic [31:0] c1_reg, c2_reg, c3_reg, c4_reg, c5_reg, tgt_reg;
      ptwf_state_t state_reg;
      logic [31:0] pos_reg;
      logic [15:0] rep_reg, iter_reg;
      logic [3:0] bit_reg;
      logic wave_reg, neg_reg;
      logic sel, c1_wr, fire, idle_lvl, pos_last, rep_last, finish, stop, pulse, advance;
      logic [2:0] pat;
      logic [15:0] count;
      logic [31:0] pw_cyc, cyc_cyc, len_cyc, pos_nxt, diff;
      logic [3:0] bit_nxt;

      // writes land in the indexed unit
      assign sel = wr.valid && (idx_reg == UNIT_IDX_W'(u));
      assign c1_wr = sel && (wr.addr == OFS_CTRL1);
      assign pat = c1_reg[PAT_LSB +: 3];
      assign pulse = (pat == PAT_NPULSE) || (pat == PAT_PPULSE);
      assign idle_lvl = (pat != PAT_SHIFT) && !pat[0];
      assign count = c3_reg[COUNT_LSB +: 16];

      // pulse width in 8 ns units with extension byte
      assign pw_cyc = ptwf_min1(32'(c5_reg[PW_FULL_W-1:0]) * 32'(PW_CYC_PER_UNIT));
      // ns period; the floor keeps a phase at least one clock
      assign cyc_cyc = ptwf_min1(c2_reg / 32'(CLK_NS));
      assign len_cyc = pulse ? pw_cyc : cyc_cyc;

      // position, bit and repeat stepping
      assign pos_last = (pos_reg >= len_cyc - 32'h1);
      assign rep_last = (count != 16'h0) && (rep_reg + 16'h1 == count);
      assign finish = pos_last && (pulse || rep_last);
      assign pos_nxt = pos_last ? 32'h0 : pos_reg + 32'h1;
      assign bit_nxt = pos_last ? bit_reg + 4'h1 : bit_reg;

      // exact arrival, or already past with the immediate bit
      assign diff = I_SYS_TIME - tgt_reg;
      assign fire = (pat != PAT_RSVD) &&
                    ((diff == 32'h0) || (c1_reg[NOW_BIT] && !diff[31]));

      // non-tail cascade units stop with the tail of the chain
      assign stop = chain_stop && c1_reg[CASC_EN_BIT] && !c1_reg[TAIL_BIT];
      assign advance = (state_reg == ST_RUN) && finish && c1_reg[CASC_EN_BIT] && !stop;

      // configuration registers of this unit
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
         if (!I_RESET_N) begin
            c1_reg <= REG_RESET;
            c2_reg <= REG_RESET;
            c3_reg <= REG_RESET;
            c4_reg <= REG_RESET;
            c5_reg <= REG_RESET;
         end else if (sel) begin
            case (wr.addr)
               OFS_CTRL1: c1_reg <= ptwf_merge(c1_reg, wr.data, wr.strb, CTRL1_WMASK);
               OFS_CTRL2: c2_reg <= ptwf_merge(c2_reg, wr.data, wr.strb, FULL_WMASK);
               // pattern bits share this word with the count
               OFS_CTRL3: c3_reg <= ptwf_merge(c3_reg, wr.data, wr.strb, FULL_WMASK);
               OFS_CTRL4: c4_reg <= ptwf_merge(c4_reg, wr.data, wr.strb, FULL_WMASK);
               OFS_CTRL5: c5_reg <= ptwf_merge(c5_reg, wr.data, wr.strb, CTRL5_WMASK);
               default: ;
            endcase
         end
      end

      // target time; a software write beats a cascade step
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
         if (!I_RESET_N) begin
            tgt_reg <= REG_RESET;
         end else if (sel && (wr.addr == OFS_TARGET)) begin
            tgt_reg <= ptwf_merge(tgt_reg, wr.data, wr.strb, FULL_WMASK);
         end else if (advance) begin
            // next pass starts one pass period later
            tgt_reg <= tgt_reg + c4_reg;
         end
      end

      // run sequencer and output level
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
         if (!I_RESET_N) begin
            state_reg <= ST_IDLE;
            pos_reg <= 32'h0;
            rep_reg <= 16'h0;
            iter_reg <= 16'h0;
            bit_reg <= 4'h0;
            wave_reg <= WAVE_RESET;
         end else if (c1_wr || !en_reg[u]) begin
            // reprogramming or disabling returns to idle
            state_reg <= ST_IDLE;
            wave_reg <= idle_lvl;
            iter_reg <= 16'h0;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
                  wave_reg <= idle_lvl;
                  iter_reg <= 16'h0;
                  state_reg <= ST_ARMED;
               end
               ST_ARMED: begin
                  if (stop) begin
                     state_reg <= ST_DONE;
                  end else if (fire) begin
                     pos_reg <= 32'h0;
                     rep_reg <= 16'h0;
                     bit_reg <= 4'h0;
                     wave_reg <= wave_at(pat, 32'h0, pw_cyc, 4'h0, c3_reg[15:0]);
                     // single edges hold their new level
                     if ((pat == PAT_FALL) || (pat == PAT_RISE)) begin
                        state_reg <= ST_DONE;
                     end else begin
                        state_reg <= ST_RUN;
                     end
                  end
               end
               ST_RUN: begin
                  if (stop) begin
                     state_reg <= ST_DONE;
                     wave_reg <= idle_lvl;
                  end else if (finish) begin
                     // finite runs end at the idle level
                     wave_reg <= idle_lvl;
                     iter_reg <= iter_reg + 16'h1;
                     // tail stops after field plus one passes
                     if (!c1_reg[CASC_EN_BIT] ||
                         (c1_reg[TAIL_BIT] && (iter_reg == c1_reg[15:0]))) begin
                        state_reg <= ST_DONE;
                     end else begin
                        state_reg <= ST_ARMED;
                     end
                  end else begin
                     // step phase, bit and repeat count
                     pos_reg <= pos_nxt;
                     bit_reg <= bit_nxt;
                     if (pos_last) begin
                        rep_reg <= rep_reg + 16'h1;
                     end
                     wave_reg <= wave_at(pat, pos_nxt, pw_cyc, bit_nxt, c3_reg[15:0]);
                  end
               end
               ST_DONE: begin
               end
            endcase
         end
      end

      // half-cycle copy for falling-edge launch
      always_ff @(negedge I_CLK or negedge I_RESET_N) begin
         if (!I_RESET_N) begin
            neg_reg <= WAVE_RESET;
         end else begin
            neg_reg <= wave_reg;
         end
      end

      // edge select picks the launching clock edge
      assign O_TRIG_OUT[u] = c1_reg[EDGE_BIT] ? neg_reg : wave_reg;

      // exports for the read mux and chain control
      assign running[u] = (state_reg == ST_RUN);
      assign done[u] = (state_reg == ST_DONE);
      assign tail_done[u] = done[u] && c1_reg[CASC_EN_BIT] && c1_reg[TAIL_BIT];
      assign tgt_q[u] = tgt_reg;
      assign c1_q[u] = c1_reg;
      assign c2_q[u] = c2_reg;
      assign c3_q[u] = c3_reg;
      assign c4_q[u] = c4_reg;
      assign c5_q[u] = c5_reg;
   end

endmodule

// >>> ptwf_checker.sv
// ptwf_checker: bus and pin assertions for ptwf_top
// assumes it is bound to ptwf_top and sees only its ports
`timescale 1ns/1ps
module ptwf_checker (
   input wire logic I_CLK, // clock
   input wire logic I_RESET_N, // reset, low
   input wire logic I_AWVALID, // aw valid
   input wire logic O_AWREADY, // aw ready
   input wire logic [ptwf_pkg::AXI_ADDR_W-1:0] I_AWADDR, // aw addr
   input wire logic I_WVALID, // w valid
   input wire logic O_WREADY, // w ready
   input wire logic O_BVALID, // b valid
   input wire logic I_BREADY, // b ready
   input wire logic [1:0] O_BRESP, // b resp
   input wire logic O_ARREADY, // ar ready
   input wire logic O_RVALID, // r valid
   input wire logic I_RREADY, // r ready
   input wire logic [31:0] O_RDATA, // r data
   input wire logic [1:0] O_RRESP, // r resp
   input wire logic [ptwf_pkg::NUM_UNITS-1:0] O_TRIG_OUT // pins
);
   import ptwf_pkg::*;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   logic touched_reg;
   ////////////////////////////////////////
   // pins may only move once enable or pattern was written; set early, at the address
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) touched_reg <= 1'b0;
      else if (I_AWVALID && O_AWREADY && (I_AWADDR == OFS_ENABLE || I_AWADDR == OFS_CTRL1))
         touched_reg <= 1'b1;
   end
   property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_after; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID;
   endproperty
   a_b_after: assert property (p_b_after) else $error("no write response");
   // a taken address and data word are held until committed, so both readies drop
   property p_aw_block; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |=> !O_AWREADY && !O_WREADY; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
   property p_ar_block; O_RVALID |-> !O_ARREADY; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_bad_rd; O_RVALID && O_RRESP == RESP_SLVERR |-> O_RDATA == 32'h0; endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("refused read carries data");
   property p_bresp; O_BVALID |-> O_BRESP == RESP_OKAY || O_BRESP == RESP_SLVERR; endproperty
   a_bresp: assert property (p_bresp) else $error("odd write response");
   property p_idle; !touched_reg |-> O_TRIG_OUT == 4'hf; endproperty
   a_idle: assert property (p_idle) else $error("pin moved while unarmed");
   c_slverr: cover property (O_BVALID && O_BRESP == RESP_SLVERR);
   c_fall: cover property ($fell(O_TRIG_OUT[0]));
   c_rise: cover property ($rose(O_TRIG_OUT[0]));
endmodule

// >>> tb_ptp_event_trigger_output_waveform.sv
// tb_ptp_event_trigger_output_waveform: self-checking bench for ptwf_top
// assumes ptwf_pkg, ptwf_top and ptwf_checker are compiled first
`timescale 1ns/1ps
module tb_ptp_event_trigger_output_waveform;
   import ptwf_pkg::*;
   logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0;
   logic I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
   logic [15:0] I_AWADDR = 16'h0, I_ARADDR = 16'h0;
   logic [31:0] I_SYS_TIME = 32'h0, I_WDATA = 32'h0, rd, wa, wb, seed = 32'h42;
   logic [3:0] I_WSTRB = 4'hf;
   logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
   logic [1:0] O_BRESP, O_RRESP, resp;
   logic [31:0] O_RDATA;
   logic [3:0] O_TRIG_OUT;
   int fails = 0, compares = 0, cyc = 0;
   logic [31:0] pats [10] = '{32'h0, 32'h0010_0000, 32'h0020_0000, 32'h0030_0000,
      32'h0040_0000, 32'h0050_0000, 32'h0060_0000, 32'h0070_0000, 32'h00b0_0000, 32'h0230_0000};
   ptwf_top dut (.*);
   always #2 I_CLK = ~I_CLK;
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected pin level k cycles after the firing edge
   function automatic logic exp_lvl(input logic [2:0] p, input int k, pw2, per, cnt,
                                    input logic [15:0] b, input logic l0);
      case (p)
         PAT_FALL: return 1'b0;
         PAT_RISE: return 1'b1;
         PAT_NPULSE: return !(k < pw2);
         PAT_PPULSE: return k < pw2;
         PAT_NPER, PAT_PPER: return (k < cnt * per && k % per < pw2) == (p == PAT_PPER);
         PAT_SHIFT: return b[15 - (k / per) % 16];
         default: return l0;
      endcase
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // a hang ends here; the longest run needs a couple of hundred cycles
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ready is looked at on the falling edge so the rising edge never races it
   task axw(input logic [15:0] a, input logic [31:0] d);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge I_CLK);
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_AWADDR <= a;
      I_WDATA <= d;
      while (pa || pw) begin
         @(negedge I_CLK);
         pa = pa && !O_AWREADY;
         pw = pw && !O_WREADY;
         @(posedge I_CLK);
         I_AWVALID <= pa;
         I_WVALID <= pw;
      end
      do @(negedge I_CLK); while (!O_BVALID);
      resp = O_BRESP;
      @(posedge I_CLK);
      I_BREADY <= 1'b1;
      @(posedge I_CLK);
      I_BREADY <= 1'b0;
   endtask
   task axr(input logic [15:0] a);
      @(posedge I_CLK);
      I_ARVALID <= 1'b1;
      I_ARADDR <= a;
      do @(negedge I_CLK); while (!O_ARREADY);
      @(posedge I_CLK);
      I_ARVALID <= 1'b0;
      do @(negedge I_CLK); while (!O_RVALID);
      rd = O_RDATA;
      resp = O_RRESP;
      @(posedge I_CLK);
      I_RREADY <= 1'b1;
      @(posedge I_CLK);
      I_RREADY <= 1'b0;
   endtask
   // program unit 0, fire it and follow the pin cycle by cycle
   task run(input logic [31:0] c1);
      logic [31:0] r;
      logic l0, e0;
      int pw2, per, cnt, n;
      r = rnd();
      pw2 = 2 * (1 + r[1:0]);
      per = 20 + r[4:2];
      cnt = 1 + r[6:5];
      n = (c1[22:20] == PAT_SHIFT) ? cnt * per : 5 * per;
      I_SYS_TIME <= 32'h0;
      axw(OFS_ENABLE, 32'h0);
      axw(OFS_CTRL1, c1);
      axw(OFS_CTRL2, 32'(per * 4));
      axw(OFS_CTRL3, {16'(cnt), r[31:16]});
      axw(OFS_CTRL5, 32'(pw2 / 2));
      axw(OFS_TARGET, 32'h64);
      axw(OFS_ENABLE, 32'h1);
      repeat (3) @(posedge I_CLK);
      #3 l0 = O_TRIG_OUT[0];
      e0 = exp_lvl(c1[22:20], 0, pw2, per, cnt, r[31:16], l0);
      @(posedge I_CLK);
      I_SYS_TIME <= c1[25] ? 32'hc8 : 32'h64;
      @(posedge I_CLK);
      if (!c1[25]) I_SYS_TIME <= 32'h0;
      for (int k = 0; k < n; k++) begin
         // before the falling edge a falling-edge launch still shows the old level
         #1;
         if (k == 0) chk(32'(O_TRIG_OUT[0]), 32'(c1[EDGE_BIT] ? l0 : e0));
         #2 chk(32'(O_TRIG_OUT[0]), 32'(exp_lvl(c1[22:20], k, pw2, per, cnt, r[31:16], l0)));
         @(posedge I_CLK);
      end
      $display("pattern %h done", c1[22:20]);
   endtask
   initial begin
      repeat (2) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      axr(OFS_CTRL2);
      chk(rd, 32'h0);
      axr(OFS_CTRL4);
      chk(rd, 32'h0);
      axr(16'h0600);
      chk(32'(resp), 32'(RESP_SLVERR));
      axw(16'h0600, 32'h1);
      chk(32'(resp), 32'(RESP_SLVERR));
      axw(OFS_CTRL5, 32'hffff_ffff);
      axr(OFS_CTRL5);
      chk(rd, 32'h00ff_ffff);
      wa = rnd();
      wb = rnd();
      axw(OFS_UNIT_INDEX, 32'h1);
      axw(OFS_CTRL4, wa);
      axw(OFS_UNIT_INDEX, 32'h0);
      axw(OFS_CTRL4, wb);
      axw(OFS_UNIT_INDEX, 32'h1);
      axr(OFS_CTRL4);
      chk(rd, wa);
      axw(OFS_UNIT_INDEX, 32'h0);
      axr(OFS_CTRL4);
      chk(rd, wb);
      axw(OFS_CTRL3, wa);
      axr(OFS_CTRL3);
      chk(rd, wa);
      $display("register test done");
      foreach (pats[i]) run(pats[i]);
      // cascade tail with iteration 1: two 4-cycle pulses, target steps twice by 0x28
      I_SYS_TIME <= 32'hc8;
      axw(OFS_CTRL5, 32'h2);
      axw(OFS_CTRL4, 32'h28);
      axw(OFS_TARGET, 32'h64);
      axw(OFS_CTRL1, 32'hc230_0001);
      wa = 32'h0;
      wb = 32'h0;
      rd = 32'h0;
      for (int k = 0; k < 40; k++) begin
         #3 wa += 32'(O_TRIG_OUT[0]);
         if (O_TRIG_OUT[0] && !rd[0]) wb++;
         rd = 32'(O_TRIG_OUT[0]);
         @(posedge I_CLK);
      end
      chk(wa, 32'h8);
      chk(wb, 32'h2);
      axr(OFS_TARGET);
      chk(rd, 32'hb4);
      $display("cascade test done");
      tally_and_finish();
   end
endmodule
bind ptwf_top ptwf_checker chk_i (.*);
